// >>> verilog/lsra_params.svh
// Purpose: Constants of the lane standby and rate adjust block
// Assumes: Included by bare name from the block, the peer model and the bench
// Notes: Word codes are 32-bit control words, flagged by a k bit
`ifndef LSRA_PARAMS_SVH
`define LSRA_PARAMS_SVH

// ==========================================================
// Register map, byte addresses
`define LSRA_CTRL_OFFSET 8'h00
`define LSRA_LEAK_OFFSET 8'h04
`define LSRA_STATUS_OFFSET 8'h08

// ==========================================================
// Register fields and reset values
`define LSRA_CTRL_LANE_START_BIT 0
`define LSRA_CTRL_AUTO_START_BIT 1
`define LSRA_CTRL_LOOPBACK_BIT 2
`define LSRA_CTRL_RESET 3'h0
`define LSRA_LEAK_RESET 16'h0100
`define LSRA_STATUS_PERSIST_BIT 3
`define LSRA_STATUS_SIGNAL_BIT 4

// ==========================================================
// Word counts
`define LSRA_NOTICE_BURST 6'h20
`define LSRA_CONSEC_LIMIT 4'h8
// 5000 words between rate slack words
`define LSRA_SKIP_PERIOD 13'h1388

// ==========================================================
// Control word codes, inverted forms are the bitwise complement
`define LSRA_WORD_IDLE 32'hBC3C3C3C
`define LSRA_WORD_SKIP 32'hBC1C1C1C
`define LSRA_WORD_STANDBY 32'hBC5C5C5C
`define LSRA_WORD_LOST 32'hBC7C7C7C
`define LSRA_WORD_RXERR 32'hBC9C9C9C

`endif

// >>> verilog/lsra_pkg.sv
// Purpose: Types of the lane standby and rate adjust block
// Assumes: Constants come from lsra_params.svh
// Notes: State codes are Gray from full reset through line quiet and active to standby notice
`default_nettype none
package lsra_pkg;

  // ==========================================================
  // Lane state machine
  typedef enum logic [2:0] {
    LSRA_FULL_RESET_STATE = 3'h0,
    LSRA_LINE_QUIET_STATE = 3'h1,
    LSRA_ACTIVE_STATE = 3'h3,
    LSRA_STANDBY_NOTICE_STATE = 3'h2,
    LSRA_SIGNAL_LOST_NOTICE_STATE = 3'h6
  } lsra_state_t;

endpackage
`default_nettype wire

// >>> verilog/lsra_lane.sv
// Purpose: Lane standby, signal-lost notice, rate adjust, filler and loopback
// Assumes: One lane word per sys_clk cycle on the transmit side
// Notes: APB slave, zero wait states, pslverr on unmapped addresses
// Contract
// - Active goes to standby notice when lane start and auto start both low
// - Standby notice sends a burst of 32 sleep notice words
// - Notice exits: full reset first, then partial reset, then others
// - After 32 sleep notice words sent, go to line quiet
// - 8 consecutive carrier gone or sleep words received go to line quiet
// - Active goes to signal lost notice when receiver has no signal
// - Fault counter overflow in Active goes to signal lost, flags persistent error
// - Fault counter is a leaky bucket: up per fault word, down periodically
// - Leak removes one count every 256 words, period settable by software
// - Signal lost notice sends a burst of 32 carrier gone words
// - After 32 carrier gone words sent, go to line quiet unless reset
// - Received words pass through an elastic buffer
// - Transmitter inserts one rate slack word every 5000 words
// - Slack word read from buffer above half full is dropped
// - Slack word read from buffer at or below half full stays for next read
// - A slack word is read at most twice, removed on the second read
// - Filler word is sent whenever nothing else is pending
// - Filler words and inverses are discarded at buffer read
// - Optional loopback routes transmit words into the receive input
`timescale 1ns/100ps
`default_nettype none
`include "lsra_params.svh"
module lsra_lane import lsra_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int ERR_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Lane control
  input wire logic full_reset_request,
  input wire logic partial_reset_request,
  input wire logic init_done,
  output logic persistent_error,
  // Upper layer transmit
  input wire logic up_tx_valid,
  input wire logic [31:0] up_tx_word,
  input wire logic up_tx_k,
  output logic up_tx_ready,
  // Upper layer receive
  output logic up_rx_valid,
  output logic [31:0] up_rx_word,
  output logic up_rx_k,
  // Encoding layer
  output logic [31:0] enc_tx_word,
  output logic enc_tx_k,
  input wire logic enc_rx_valid,
  input wire logic [31:0] enc_rx_word,
  input wire logic enc_rx_k,
  input wire logic rx_signal_present
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [ERR_W-1:0] ERR_MAX = {ERR_W{1'b1}};

  lsra_state_t state_reg, state_next;
  logic [2:0] ctrl_reg;
  logic [15:0] leak_period_reg;
  logic persist_reg;
  logic sig_s1_reg, sig_s2_reg, sig_s3_reg, sig_present_reg;
  logic [12:0] skip_cnt_reg;
  logic [5:0] burst_cnt_reg;
  logic [31:0] tx_word_next;
  logic tx_k_next;
  logic skip_due, notice_sel, burst_done;
  logic [31:0] mem [DEPTH];
  logic [DEPTH-1:0] mem_k;
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic skip_seen_reg;
  logic in_valid, in_k, wr_en, empty, pop, deliver;
  logic [31:0] in_word, head_word;
  logic head_k, is_skip, is_idle, is_stby, is_lost, is_rxerr, is_lane_ctrl;
  logic [3:0] stby_cnt_reg, lost_cnt_reg;
  logic rx_hit8, in_notice, in_active;
  logic [15:0] leak_cnt_reg;
  logic leak_tick, err_inc;
  logic [ERR_W-1:0] err_cnt_reg;
  logic err_ovf_reg;
  logic apb_access, apb_hit;

  // ==========================================================
  // APB slave
  assign apb_access = psel && penable;
  assign apb_hit = (paddr == `LSRA_CTRL_OFFSET) || (paddr == `LSRA_LEAK_OFFSET) ||
                   (paddr == `LSRA_STATUS_OFFSET);
  assign pready = 1'b1;
  assign pslverr = apb_access && !apb_hit;

  always_comb begin
    prdata = 32'h00000000;
    case (paddr)
      `LSRA_CTRL_OFFSET: prdata = {29'h00000000, ctrl_reg};
      `LSRA_LEAK_OFFSET: prdata = {16'h0000, leak_period_reg};
      `LSRA_STATUS_OFFSET: prdata = {8'h00, 8'(err_cnt_reg), 3'h0, 5'(count_reg),
                                     3'h0, sig_present_reg, persist_reg, 3'(state_reg)};
      default: prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `LSRA_CTRL_RESET;
      leak_period_reg <= `LSRA_LEAK_RESET;
    end else if (apb_access && pwrite) begin
      if (paddr == `LSRA_CTRL_OFFSET) begin
        ctrl_reg <= pwdata[2:0];
      end
      if (paddr == `LSRA_LEAK_OFFSET) begin
        leak_period_reg <= pwdata[15:0];
      end
    end
  end

  // Set wins over a write-one clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      persist_reg <= 1'b0;
    end else if (err_ovf_reg) begin
      persist_reg <= 1'b1;
    end else if (apb_access && pwrite && paddr == `LSRA_STATUS_OFFSET &&
                 pwdata[`LSRA_STATUS_PERSIST_BIT]) begin
      persist_reg <= 1'b0;
    end
  end
  assign persistent_error = persist_reg;

  // ==========================================================
  // Signal detect synchroniser
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sig_s1_reg <= 1'b0;
      sig_s2_reg <= 1'b0;
      sig_s3_reg <= 1'b0;
      sig_present_reg <= 1'b0;
    end else begin
      sig_s1_reg <= rx_signal_present;
      sig_s2_reg <= sig_s1_reg;
      sig_s3_reg <= sig_s2_reg;
      if (sig_s2_reg == sig_s3_reg) begin
        sig_present_reg <= sig_s3_reg;
      end
    end
  end

  // ==========================================================
  // Lane state machine
  assign in_active = (state_reg == LSRA_ACTIVE_STATE);
  assign in_notice = (state_reg == LSRA_STANDBY_NOTICE_STATE) ||
                     (state_reg == LSRA_SIGNAL_LOST_NOTICE_STATE);
  assign burst_done = (burst_cnt_reg == `LSRA_NOTICE_BURST);
  assign rx_hit8 = (stby_cnt_reg == `LSRA_CONSEC_LIMIT) ||
                   (lost_cnt_reg == `LSRA_CONSEC_LIMIT);

  always_comb begin
    state_next = state_reg;
    if (full_reset_request) begin
      state_next = LSRA_FULL_RESET_STATE;
    end else begin
      case (state_reg)
        LSRA_FULL_RESET_STATE: state_next = LSRA_LINE_QUIET_STATE;
        LSRA_LINE_QUIET_STATE: begin
          if (init_done && !partial_reset_request) begin
            state_next = LSRA_ACTIVE_STATE;
          end
        end
        LSRA_ACTIVE_STATE: begin
          if (partial_reset_request) begin
            state_next = LSRA_LINE_QUIET_STATE;
          end else if (!sig_present_reg) begin
            state_next = LSRA_SIGNAL_LOST_NOTICE_STATE;
          end else if (err_ovf_reg) begin
            state_next = LSRA_SIGNAL_LOST_NOTICE_STATE;
          end else if (!ctrl_reg[`LSRA_CTRL_LANE_START_BIT] &&
                       !ctrl_reg[`LSRA_CTRL_AUTO_START_BIT]) begin
            state_next = LSRA_STANDBY_NOTICE_STATE;
          end else if (rx_hit8) begin
            state_next = LSRA_LINE_QUIET_STATE;
          end
        end
        LSRA_STANDBY_NOTICE_STATE, LSRA_SIGNAL_LOST_NOTICE_STATE: begin
          if (partial_reset_request) begin
            state_next = LSRA_LINE_QUIET_STATE;
          end else if (burst_done) begin
            state_next = LSRA_LINE_QUIET_STATE;
          end else if (rx_hit8) begin
            state_next = LSRA_LINE_QUIET_STATE;
          end
        end
        default: state_next = LSRA_FULL_RESET_STATE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= LSRA_FULL_RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Transmit word selection
  assign skip_due = (skip_cnt_reg == `LSRA_SKIP_PERIOD - 13'h0001);
  assign notice_sel = in_notice && !burst_done;
  // Upper layer stalls for the slack slot rather than losing a word
  assign up_tx_ready = in_active && !skip_due;

  always_comb begin
    tx_word_next = `LSRA_WORD_IDLE;
    tx_k_next = 1'b1;
    if (skip_due) begin
      tx_word_next = `LSRA_WORD_SKIP;
    end else if (notice_sel && state_reg == LSRA_STANDBY_NOTICE_STATE) begin
      tx_word_next = `LSRA_WORD_STANDBY;
    end else if (notice_sel) begin
      tx_word_next = `LSRA_WORD_LOST;
    end else if (up_tx_valid && up_tx_ready) begin
      tx_word_next = up_tx_word;
      tx_k_next = up_tx_k;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enc_tx_word <= `LSRA_WORD_IDLE;
      enc_tx_k <= 1'b1;
    end else begin
      enc_tx_word <= tx_word_next;
      enc_tx_k <= tx_k_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      skip_cnt_reg <= 13'h0000;
    end else if (skip_due) begin
      skip_cnt_reg <= 13'h0000;
    end else begin
      skip_cnt_reg <= skip_cnt_reg + 13'h0001;
    end
  end

  // Slack slots delay the burst but do not count toward it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      burst_cnt_reg <= 6'h00;
    end else if (!in_notice) begin
      burst_cnt_reg <= 6'h00;
    end else if (notice_sel && !skip_due) begin
      burst_cnt_reg <= burst_cnt_reg + 6'h01;
    end
  end

  // ==========================================================
  // Receive elastic buffer
  assign in_valid = ctrl_reg[`LSRA_CTRL_LOOPBACK_BIT] ? 1'b1 : enc_rx_valid;
  assign in_word = ctrl_reg[`LSRA_CTRL_LOOPBACK_BIT] ? enc_tx_word : enc_rx_word;
  assign in_k = ctrl_reg[`LSRA_CTRL_LOOPBACK_BIT] ? enc_tx_k : enc_rx_k;
  // A full buffer drops the arriving word; slack handling keeps this rare
  assign wr_en = in_valid && (count_reg != FULL);
  assign empty = (count_reg == {CW{1'b0}});
  assign head_word = mem[rd_ptr_reg];
  assign head_k = mem_k[rd_ptr_reg];
  assign is_skip = head_k && (head_word == `LSRA_WORD_SKIP || head_word == ~`LSRA_WORD_SKIP);
  assign is_idle = head_k && (head_word == `LSRA_WORD_IDLE || head_word == ~`LSRA_WORD_IDLE);
  assign is_stby = head_k && (head_word == `LSRA_WORD_STANDBY);
  assign is_lost = head_k && (head_word == `LSRA_WORD_LOST);
  assign is_rxerr = head_k && (head_word == `LSRA_WORD_RXERR);
  assign is_lane_ctrl = is_stby || is_lost || is_rxerr;
  // Slack stays once at or below half, goes on second read or above half
  assign pop = !empty && !(is_skip && !skip_seen_reg && count_reg <= HALF);
  assign deliver = pop && !is_skip && !is_idle;

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_ptr_reg] <= in_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_k <= {DEPTH{1'b0}};
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {CW{1'b0}};
    end else begin
      if (wr_en) begin
        mem_k[wr_ptr_reg] <= in_k;
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + CW'(wr_en) - CW'(pop);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      skip_seen_reg <= 1'b0;
    end else if (pop) begin
      skip_seen_reg <= 1'b0;
    end else if (!empty && is_skip) begin
      skip_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      up_rx_valid <= 1'b0;
      up_rx_word <= 32'h00000000;
      up_rx_k <= 1'b0;
    end else begin
      up_rx_valid <= deliver && !is_lane_ctrl && in_active;
      if (deliver) begin
        up_rx_word <= head_word;
        up_rx_k <= head_k;
      end
    end
  end

  // ==========================================================
  // Consecutive notice word counters
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stby_cnt_reg <= 4'h0;
      lost_cnt_reg <= 4'h0;
    end else if (!in_active && !in_notice) begin
      stby_cnt_reg <= 4'h0;
      lost_cnt_reg <= 4'h0;
    end else if (deliver) begin
      if (!is_stby) begin
        stby_cnt_reg <= 4'h0;
      end else if (stby_cnt_reg != `LSRA_CONSEC_LIMIT) begin
        stby_cnt_reg <= stby_cnt_reg + 4'h1;
      end
      if (!is_lost) begin
        lost_cnt_reg <= 4'h0;
      end else if (lost_cnt_reg != `LSRA_CONSEC_LIMIT) begin
        lost_cnt_reg <= lost_cnt_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // Leaky bucket fault counter
  // Period of zero behaves as one, a leak every word
  assign leak_tick = (leak_cnt_reg + 16'h0001 >= leak_period_reg);
  assign err_inc = deliver && is_rxerr && in_active;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      leak_cnt_reg <= 16'h0000;
    end else if (leak_tick) begin
      leak_cnt_reg <= 16'h0000;
    end else begin
      leak_cnt_reg <= leak_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      err_cnt_reg <= {ERR_W{1'b0}};
      err_ovf_reg <= 1'b0;
    end else begin
      err_ovf_reg <= err_inc && !leak_tick && (err_cnt_reg == ERR_MAX);
      if (!in_active) begin
        err_cnt_reg <= {ERR_W{1'b0}};
      end else if (err_inc && !leak_tick && err_cnt_reg != ERR_MAX) begin
        err_cnt_reg <= err_cnt_reg + ERR_W'(1);
      end else if (leak_tick && !err_inc && err_cnt_reg != {ERR_W{1'b0}}) begin
        err_cnt_reg <= err_cnt_reg - ERR_W'(1);
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_standby_entry;
    in_active && !full_reset_request && !partial_reset_request && sig_present_reg &&
      !err_ovf_reg && ctrl_reg[1:0] == 2'b00 |=> state_reg == LSRA_STANDBY_NOTICE_STATE;
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("no standby entry");

  property p_standby_word;
    state_reg == LSRA_STANDBY_NOTICE_STATE && !burst_done && !skip_due
      |=> enc_tx_k && enc_tx_word == `LSRA_WORD_STANDBY;
  endproperty
  a_standby_word: assert property (p_standby_word) else $error("standby word missing");

  property p_full_first;
    full_reset_request |=> state_reg == LSRA_FULL_RESET_STATE;
  endproperty
  a_full_first: assert property (p_full_first) else $error("full reset not taken");

  property p_burst_done;
    in_notice && burst_done && !full_reset_request |=> state_reg == LSRA_LINE_QUIET_STATE;
  endproperty
  a_burst_done: assert property (p_burst_done) else $error("burst end ignored");

  property p_hit8;
    in_notice && rx_hit8 && !full_reset_request |=> state_reg == LSRA_LINE_QUIET_STATE;
  endproperty
  a_hit8: assert property (p_hit8) else $error("eight notices ignored");

  property p_sig_lost;
    in_active && !full_reset_request && !partial_reset_request && !sig_present_reg
      |=> state_reg == LSRA_SIGNAL_LOST_NOTICE_STATE;
  endproperty
  a_sig_lost: assert property (p_sig_lost) else $error("signal loss ignored");

  property p_overflow;
    err_ovf_reg |=> persist_reg;
  endproperty
  a_overflow: assert property (p_overflow) else $error("persistent flag lost");

  property p_leak;
    in_active && leak_tick && !err_inc && err_cnt_reg != {ERR_W{1'b0}}
      |=> err_cnt_reg == $past(err_cnt_reg) - ERR_W'(1);
  endproperty
  a_leak: assert property (p_leak) else $error("leak missed");

  property p_skip_slot;
    skip_due |=> enc_tx_k && enc_tx_word == `LSRA_WORD_SKIP ##1 !skip_due [*8];
  endproperty
  a_skip_slot: assert property (p_skip_slot) else $error("slack slot wrong");

  property p_skip_retain;
    !empty && is_skip && !skip_seen_reg && count_reg <= HALF
      |=> skip_seen_reg && rd_ptr_reg == $past(rd_ptr_reg);
  endproperty
  a_skip_retain: assert property (p_skip_retain) else $error("slack not kept");

  property p_skip_twice;
    !empty && is_skip && skip_seen_reg |=> rd_ptr_reg == $past(rd_ptr_reg) + AW'(1);
  endproperty
  a_skip_twice: assert property (p_skip_twice) else $error("slack read thrice");

  property p_skip_drop;
    !empty && is_skip && count_reg > HALF |=> rd_ptr_reg == $past(rd_ptr_reg) + AW'(1);
  endproperty
  a_skip_drop: assert property (p_skip_drop) else $error("slack above half kept");

  property p_idle_drop;
    !empty && is_idle |=> !up_rx_valid;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("filler passed up");

  c_standby_exit: cover property (state_reg == LSRA_STANDBY_NOTICE_STATE ##1
                                  state_reg == LSRA_LINE_QUIET_STATE);
  c_lost_exit: cover property (state_reg == LSRA_SIGNAL_LOST_NOTICE_STATE ##1
                               state_reg == LSRA_LINE_QUIET_STATE);
  c_skip_drop: cover property (!empty && is_skip && count_reg > HALF);
  c_overflow: cover property (err_ovf_reg);

endmodule
`default_nettype wire

// >>> tb/lsra_peer.sv
// Purpose: Peer lane end feeding the receive side
// Assumes: One word per clock toward the block
// Notes: Queued words first, filler otherwise
`timescale 1ns/100ps
`default_nettype none
`include "lsra_params.svh"
module lsra_peer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Toward the block
  output logic enc_rx_valid,
  output logic [31:0] enc_rx_word,
  output logic enc_rx_k,
  output logic rx_signal_present
);
  logic [32:0] q[$];
  logic flip;
  initial begin
    {enc_rx_valid, enc_rx_word, enc_rx_k, flip} = '0;
    rx_signal_present = 1'b1;
  end
  // ==========================================================
  // Word stream, no gaps; filler flips polarity like a swapped pair
  always @(posedge sys_clk) begin
    flip <= !flip;
    enc_rx_valid <= rstn;
    if (q.size() > 0) begin
      {enc_rx_k, enc_rx_word} <= q.pop_front();
    end else begin
      {enc_rx_k, enc_rx_word} <= {1'b1, flip ? ~`LSRA_WORD_IDLE : `LSRA_WORD_IDLE};
    end
  end
  task automatic push(input logic k, input logic [31:0] w, input int n);
    @(negedge sys_clk);
    repeat (n) q.push_back({k, w});
  endtask
  task automatic set_sig(input logic v);
    @(negedge sys_clk);
    rx_signal_present = v;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Scenario bench of the lane standby and rate adjust block
// Assumes: Peer model supplies the receive stream
// Notes: Burst counts taken from the transmit word stream
`timescale 1ns/100ps
`default_nettype none
`include "lsra_params.svh"
module tb_top import lsra_pkg::*; ;
  logic sys_clk, rstn, psel, penable, pwrite, full_reset_request, partial_reset_request;
  logic init_done, up_tx_valid, up_tx_k, pready, pslverr, persistent_error, up_tx_ready;
  logic up_rx_valid, up_rx_k, enc_tx_k, enc_rx_valid, enc_rx_k, rx_signal_present, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, up_tx_word, rd, prdata, up_rx_word, enc_tx_word, enc_rx_word, rx_last;
  int err_count, comparisons, std_n, lost_n, rx_n, s0, n;
  lsra_lane #(.DEPTH(16), .ERR_W(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .full_reset_request(full_reset_request),
    .partial_reset_request(partial_reset_request), .init_done(init_done),
    .persistent_error(persistent_error), .up_tx_valid(up_tx_valid), .up_tx_word(up_tx_word),
    .up_tx_k(up_tx_k), .up_tx_ready(up_tx_ready), .up_rx_valid(up_rx_valid),
    .up_rx_word(up_rx_word), .up_rx_k(up_rx_k), .enc_tx_word(enc_tx_word),
    .enc_tx_k(enc_tx_k), .enc_rx_valid(enc_rx_valid), .enc_rx_word(enc_rx_word),
    .enc_rx_k(enc_rx_k), .rx_signal_present(rx_signal_present));
  lsra_peer peer (.sys_clk(sys_clk), .rstn(rstn), .enc_rx_valid(enc_rx_valid),
    .enc_rx_word(enc_rx_word), .enc_rx_k(enc_rx_k), .rx_signal_present(rx_signal_present));
  // ==========================================================
  // Clock and monitors
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (up_rx_valid === 1'b1) begin
      rx_last <= up_rx_word;
      rx_n <= rx_n + 1;
      if (up_rx_word inside {`LSRA_WORD_IDLE, ~`LSRA_WORD_IDLE, `LSRA_WORD_SKIP}) begin
        err_count++;
        $display("MISMATCH up_rx_word expected data seen %h", up_rx_word);
      end
    end
    if (enc_tx_word === `LSRA_WORD_STANDBY) std_n <= std_n + 1;
    if (enc_tx_word === `LSRA_WORD_LOST) lost_n <= lost_n + 1;
  end
  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Request held until the edge at which pready is sampled high
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      err_count++;
      print_verdict();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic st(input logic [2:0] e);
    apb(1'b0, `LSRA_STATUS_OFFSET, 32'h0);
    chk("state", {29'h0, e}, {29'h0, rd[2:0]});
  endtask
  task automatic bring_up();
    apb(1'b1, `LSRA_CTRL_OFFSET, 32'h1);
    @(posedge sys_clk) init_done <= 1'b1;
    @(posedge sys_clk) init_done <= 1'b0;
    st(3'h3);
  endtask
  task automatic tx(input logic [31:0] w);
    @(posedge sys_clk) {up_tx_valid, up_tx_k, up_tx_word} <= {2'b10, w};
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (up_tx_ready === 1'b1) break;
    end
    chk("up_tx_ready", 32'h1, {31'h0, up_tx_ready});
    up_tx_valid <= 1'b0;
    @(negedge sys_clk) chk("enc_tx_word", w, enc_tx_word);
    chk("enc_tx_k", 32'h0, {31'h0, enc_tx_k});
    @(negedge sys_clk) chk("filler", `LSRA_WORD_IDLE, enc_tx_word);
  endtask
  task automatic rx_expect(input logic [31:0] w);
    s0 = rx_n;
    for (n = 0; n < 60 && rx_n == s0; n++) @(negedge sys_clk);
    chk("up_rx_word", w, rx_last);
    chk("rx_n", s0 + 1, rx_n);
    chk("up_rx_k", 32'h0, {31'h0, up_rx_k});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs_data();
    apb(1'b0, `LSRA_LEAK_OFFSET, 32'h0);
    chk("leak reset", 32'h00000100, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, slv});
    bring_up();
    peer.push(1'b0, 32'h11112222, 1);
    peer.push(1'b1, `LSRA_WORD_SKIP, 1);
    peer.push(1'b0, 32'h33334444, 1);
    rx_expect(32'h11112222);
    rx_expect(32'h33334444);
    peer.push(1'b1, `LSRA_WORD_SKIP, 24);
    peer.push(1'b0, 32'h77778888, 1);
    rx_expect(32'h77778888);
    apb(1'b0, `LSRA_STATUS_OFFSET, 32'h0);
    chk("fill above half", 32'h9, {27'h0, rd[12:8]});
    tx(32'hABCD0123);
    apb(1'b1, `LSRA_CTRL_OFFSET, 32'h5);
    tx(32'h5EED0001);
    rx_expect(32'h5EED0001);
  endtask
  task automatic t_fault();
    apb(1'b1, `LSRA_CTRL_OFFSET, 32'h2);
    apb(1'b1, `LSRA_LEAK_OFFSET, 32'h8);
    repeat (20) begin
      peer.push(1'b1, `LSRA_WORD_RXERR, 1);
      peer.push(1'b1, `LSRA_WORD_IDLE, 9);
    end
    repeat (210) @(posedge sys_clk);
    chk("persistent leak", 32'h0, {31'h0, persistent_error});
    st(3'h3);
    apb(1'b1, `LSRA_LEAK_OFFSET, 32'hFFFF);
    s0 = lost_n;
    peer.push(1'b1, `LSRA_WORD_RXERR, 16);
    peer.push(1'b1, `LSRA_WORD_LOST, 8);
    repeat (60) @(posedge sys_clk);
    chk("persistent", 32'h1, {31'h0, persistent_error});
    chk("lost cut", 32'h1, {31'h0, lost_n - s0 < 32});
    st(3'h1);
    apb(1'b1, `LSRA_STATUS_OFFSET, 32'h8);
    @(negedge sys_clk);
    chk("persistent clear", 32'h0, {31'h0, persistent_error});
  endtask
  task automatic t_notice();
    bring_up();
    s0 = lost_n;
    peer.set_sig(1'b0);
    repeat (6) @(posedge sys_clk);
    st(3'h6);
    repeat (50) @(posedge sys_clk);
    chk("lost burst", 32'd32, lost_n - s0);
    st(3'h1);
    peer.set_sig(1'b1);
    repeat (8) @(posedge sys_clk);
    bring_up();
    s0 = std_n;
    apb(1'b1, `LSRA_CTRL_OFFSET, 32'h0);
    st(3'h2);
    peer.push(1'b1, `LSRA_WORD_STANDBY, 7);
    peer.push(1'b0, 32'h5A5A5A5A, 1);
    peer.push(1'b1, `LSRA_WORD_STANDBY, 7);
    repeat (60) @(posedge sys_clk);
    chk("standby burst", 32'd32, std_n - s0);
    st(3'h1);
  endtask
  task automatic t_reset_skip();
    bring_up();
    apb(1'b1, `LSRA_CTRL_OFFSET, 32'h0);
    @(posedge sys_clk) {full_reset_request, partial_reset_request} <= 2'b11;
    repeat (3) @(posedge sys_clk);
    st(3'h0);
    @(posedge sys_clk) full_reset_request <= 1'b0;
    repeat (3) @(posedge sys_clk);
    st(3'h1);
    partial_reset_request <= 1'b0;
    for (n = 0; n < 5100 && enc_tx_word !== `LSRA_WORD_SKIP; n++) @(negedge sys_clk);
    for (n = 1; n < 5100; n++) begin
      @(negedge sys_clk);
      if (enc_tx_word === `LSRA_WORD_SKIP) break;
    end
    chk("slack period", 32'd5000, n);
  endtask
  // ==========================================================
  // Main sequence and hang guard
  initial begin
    {rstn, psel, penable, pwrite, full_reset_request, partial_reset_request} = '0;
    {init_done, up_tx_valid, up_tx_k, paddr, pwdata, up_tx_word, rx_last} = '0;
    {err_count, comparisons, std_n, lost_n, rx_n} = '0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs_data();
    t_fault();
    t_notice();
    t_reset_skip();
    print_verdict();
  end
  initial begin
    #900000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
